// File: src/ssdl_pkg.sv
// Package: shared constants for the divider-load serial port
`default_nettype none
package ssdl_pkg;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int FRAME_BITS = 25;
   localparam int DATA_LSB = 0;
   localparam int DATA_MSB = 15;
   localparam int REG_LSB = 16;
   localparam int REG_MSB = 20;
   localparam int DEV_LSB = 21;
   localparam int DEV_MSB = 24;
   // Chip code value is arbitrary
   localparam logic [3:0] DEV_CODE = 4'h5;
   // ----------------------------------------
   // Register addresses (chosen)
   // ----------------------------------------
   localparam logic [4:0] ADDR_REF_DIV = 5'h00;
   localparam logic [4:0] ADDR_FB_LOW = 5'h01;
   localparam logic [4:0] ADDR_FB_HIGH = 5'h02;
   localparam logic [15:0] REF_DIV_RESET = 16'h0001;
   localparam logic [15:0] FB_LOW_RESET = 16'h0000;
   localparam logic [15:0] FB_HIGH_RESET = 16'h0000;
   // ----------------------------------------
   // Host APB registers (chosen)
   // ----------------------------------------
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_CLKDIV = 8'h08;
   localparam logic [7:0] CLKDIV_RESET = 8'h04;
   // ----------------------------------------
   // Timing: least times on the serial lines
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_ENABLE_HIGH_NS = 10;
   localparam int T_FALL_TO_LOAD_NS = 20;
   localparam int ENABLE_HIGH_CYC = (T_ENABLE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FALL_TO_LOAD_CYC = (T_FALL_TO_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0]
   {
      SSDL_IDLE = 2'b00,
      SSDL_SHIFT = 2'b01,
      SSDL_GAP = 2'b10,
      SSDL_LOAD = 2'b11
   } ssdl_state_t;
endpackage
`default_nettype wire

// File: src/ssdl_link_if.sv
// Interface: three-wire write-only serial link
`default_nettype none
interface ssdl_link_if;
   logic serial_clk;
   logic serial_data;
   logic load_strobe;
   modport host (output serial_clk, output serial_data, output load_strobe);
   modport device (input serial_clk, input serial_data, input load_strobe);
endinterface
`default_nettype wire

// File: src/ssdl_device.sv
// Device end: serial receiver, divider registers and divider/lock logic
// Overview of operation
// - Three host-driven lines, no readback
// - Each frame is exactly 25 bits
// - Low sixteen bits carry data
// - Bits 20 to 16 register address
// - Top four bits device code, checked
// - Reference and two feedback registers
// - Registers: 16 data bits, address above
// - Reference register sets comparison rate
// - High feedback bits 1:0 are MSBs
// - Low feedback register gives sixteen LSBs
// - Host keeps reference ratio 1..2047
// - Main and swallow counts for a dual-modulus prescaler
// - Lock output high while locked
//
// Local design decisions: the register addresses and the APB slave port.
`default_nettype none
module ssdl_device
   import ssdl_pkg::*;
#(
   parameter int LOCK_COUNT = 16,
   parameter int LOCK_WINDOW = 2
)
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   ssdl_link_if.device link,
   input wire logic ref_clk_in,
   input wire logic vco_clk_in,
   input wire logic prescaler_sel_in,
   output logic [15:0] ref_div_out,
   output logic [17:0] fb_div_out,
   output logic [12:0] main_count_out,
   output logic [4:0] swallow_count_out,
   output logic lock_indicator_out
);
   initial
   begin
      if (LOCK_COUNT < 1 || LOCK_COUNT > 255 || LOCK_WINDOW < 1 || LOCK_WINDOW > 255)
      begin
         $error("ssdl_device: bad lock parameters");
      end
   end
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [5:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
   always_comb
   begin
      s1_d = {prescaler_sel_in, vco_clk_in, ref_clk_in, link.load_strobe, link.serial_data,
         link.serial_clk};
      s2_d = s1_q;
      s3_d = s2_q;
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
         s3_q <= 6'h00;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   logic sclk_rise, load_rise, ref_rise, vco_rise;
   always_comb
   begin
      sclk_rise = s2_q[0] & ~s3_q[0];
      load_rise = s2_q[2] & ~s3_q[2];
      ref_rise = s2_q[3] & ~s3_q[3];
      vco_rise = s2_q[4] & ~s3_q[4];
   end
   // ----------------------------------------
   // Serial shift and commit
   // ----------------------------------------
   logic [24:0] shift_q, shift_d;
   logic [5:0] count_q, count_d;
   logic [15:0] ref_q, ref_d, fbl_q, fbl_d, fbh_q, fbh_d;
   logic [3:0] dev_f;
   logic [4:0] reg_f;
   always_comb
   begin
      shift_d = shift_q;
      count_d = count_q;
      ref_d = ref_q;
      fbl_d = fbl_q;
      fbh_d = fbh_q;
      dev_f = shift_q[DEV_MSB:DEV_LSB];
      reg_f = shift_q[REG_MSB:REG_LSB];
      if (sclk_rise && !s2_q[2])
      begin
         shift_d = {shift_q[23:0], s2_q[1]};
         if (count_q != 6'h3f)
         begin
            count_d = count_q + 6'h01;
         end
      end
      if (load_rise)
      begin
         count_d = 6'h00;
         // full frame and matching code only
         if (count_q == 6'(FRAME_BITS) && dev_f == DEV_CODE)
         begin
            if (reg_f == ADDR_REF_DIV)
            begin
               ref_d = shift_q[DATA_MSB:DATA_LSB];
            end
            else if (reg_f == ADDR_FB_LOW)
            begin
               fbl_d = shift_q[DATA_MSB:DATA_LSB];
            end
            else if (reg_f == ADDR_FB_HIGH)
            begin
               fbh_d = shift_q[DATA_MSB:DATA_LSB];
            end
         end
      end
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         shift_q <= 25'h0000000;
         count_q <= 6'h00;
         ref_q <= REF_DIV_RESET;
         fbl_q <= FB_LOW_RESET;
         fbh_q <= FB_HIGH_RESET;
      end
      else
      begin
         shift_q <= shift_d;
         count_q <= count_d;
         ref_q <= ref_d;
         fbl_q <= fbl_d;
         fbh_q <= fbh_d;
      end
   end
   // ----------------------------------------
   // Divider values and counters
   // ----------------------------------------
   logic [17:0] n_val;
   logic [5:0] p_val;
   logic [12:0] m_val;
   logic [4:0] s_val;
   always_comb
   begin
      n_val = {fbh_q[1:0], fbl_q};
      // N = P*M - S, so M = ceil(N/P), S = P*M - N
      if (s2_q[5])
      begin
         p_val = 6'h20;
         m_val = 13'(n_val[17:5] + {12'h000, |n_val[4:0]});
         s_val = 5'((~n_val[4:0]) + 5'h01);
      end
      else
      begin
         p_val = 6'h10;
         m_val = 13'(n_val[16:4] + {12'h000, |n_val[3:0]});
         s_val = {1'b0, 4'((~n_val[3:0]) + 4'h1)};
      end
   end
   // Divide the sampled ref and vco edges; 11-bit ref counter
   logic [10:0] rcnt_q, rcnt_d;
   logic [17:0] ncnt_q, ncnt_d;
   logic rpulse, npulse;
   always_comb
   begin
      rpulse = 1'b0;
      npulse = 1'b0;
      rcnt_d = rcnt_q;
      ncnt_d = ncnt_q;
      if (ref_rise)
      begin
         if (rcnt_q + 11'h001 >= ref_q[10:0])
         begin
            rcnt_d = 11'h000;
            rpulse = 1'b1;
         end
         else
         begin
            rcnt_d = rcnt_q + 11'h001;
         end
      end
      if (vco_rise)
      begin
         if (ncnt_q + 18'h00001 >= n_val)
         begin
            ncnt_d = 18'h00000;
            npulse = 1'b1;
         end
         else
         begin
            ncnt_d = ncnt_q + 18'h00001;
         end
      end
   end
   // ----------------------------------------
   // Lock detector
   // ----------------------------------------
   logic [7:0] gap_q, gap_d, good_q, good_d;
   logic pend_q, pend_d, lock_q, lock_d;
   always_comb
   begin
      gap_d = gap_q;
      good_d = good_q;
      pend_d = pend_q;
      lock_d = lock_q;
      if (pend_q && gap_q != 8'hff)
      begin
         gap_d = gap_q + 8'h01;
      end
      if (rpulse ^ npulse)
      begin
         if (!pend_q)
         begin
            pend_d = 1'b1;
            gap_d = 8'h00;
         end
         else
         begin
            pend_d = 1'b0;
         end
      end
      if ((rpulse && npulse) || (pend_q && (rpulse ^ npulse)))
      begin
         if (rpulse && npulse || gap_q < 8'(LOCK_WINDOW))
         begin
            if (good_q != 8'(LOCK_COUNT))
            begin
               good_d = good_q + 8'h01;
            end
            else
            begin
               lock_d = 1'b1;
            end
         end
         else
         begin
            good_d = 8'h00;
            lock_d = 1'b0;
         end
      end
      else if (pend_q && gap_q >= 8'(LOCK_WINDOW))
      begin
         good_d = 8'h00;
         lock_d = 1'b0;
      end
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rcnt_q <= 11'h000;
         ncnt_q <= 18'h00000;
         gap_q <= 8'h00;
         good_q <= 8'h00;
         pend_q <= 1'b0;
         lock_q <= 1'b0;
         ref_div_out <= REF_DIV_RESET;
         fb_div_out <= 18'h00000;
         main_count_out <= 13'h0000;
         swallow_count_out <= 5'h00;
         lock_indicator_out <= 1'b0;
      end
      else
      begin
         rcnt_q <= rcnt_d;
         ncnt_q <= ncnt_d;
         gap_q <= gap_d;
         good_q <= good_d;
         pend_q <= pend_d;
         lock_q <= lock_d;
         ref_div_out <= ref_q;
         fb_div_out <= n_val;
         main_count_out <= m_val;
         swallow_count_out <= s_val;
         lock_indicator_out <= lock_q;
      end
   end
   logic unused_p;
   assign unused_p = ^{p_val, s3_q[5], s3_q[1]};
endmodule // ssdl_device
`default_nettype wire

// File: src/ssdl_host.sv
// Host end: APB-commanded serial frame writer
`default_nettype none
module ssdl_host
   import ssdl_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   ssdl_link_if.host link
);
   // ----------------------------------------
   // Register file and control
   // ----------------------------------------
   ssdl_state_t state_q, state_d;
   logic [24:0] frame_q, frame_d;
   logic [4:0] bit_q, bit_d;
   logic [7:0] div_q, div_d, tick_q, tick_d;
   logic sclk_q, sclk_d, sdat_q, sdat_d, load_q, load_d;
   logic [31:0] rdata_d;
   logic ready_d, err_d, access;
   always_comb
   begin
      state_d = state_q;
      frame_d = frame_q;
      bit_d = bit_q;
      div_d = div_q;
      tick_d = tick_q;
      sclk_d = sclk_q;
      sdat_d = sdat_q;
      load_d = load_q;
      rdata_d = 32'h00000000;
      err_d = 1'b0;
      access = psel_in && penable_in && !pready_out;
      ready_d = access;
      if (access)
      begin
         if (paddr_in == APB_CMD)
         begin
            // chip code in top bits; address and data
            if (pwrite_in && state_q == SSDL_IDLE)
            begin
               frame_d = {DEV_CODE, pwdata_in[20:16], pwdata_in[15:0]};
               state_d = SSDL_SHIFT;
               bit_d = 5'(FRAME_BITS - 1);
               tick_d = 8'h00;
               sdat_d = DEV_CODE[3];
            end
            else if (pwrite_in)
            begin
               err_d = 1'b1;
            end
            else
            begin
               rdata_d = {7'h00, frame_q};
            end
         end
         else if (paddr_in == APB_STATUS)
         begin
            rdata_d = {31'h00000000, state_q != SSDL_IDLE};
         end
         else if (paddr_in == APB_CLKDIV)
         begin
            if (pwrite_in)
            begin
               div_d = (pwdata_in[7:0] < 8'h02) ? 8'h02 : pwdata_in[7:0];
            end
            rdata_d = {24'h000000, div_q};
         end
         else
         begin
            err_d = 1'b1;
         end
      end
      // ----------------------------------------
      // Serial engine
      // ----------------------------------------
      case (state_q)
         SSDL_SHIFT:
         begin
            tick_d = tick_q + 8'h01;
            // MSB first, rising edge mid-bit, 25 bits
            if (tick_q == {1'b0, div_q[7:1]})
            begin
               sclk_d = 1'b1;
            end
            else if (tick_q + 8'h01 >= div_q)
            begin
               sclk_d = 1'b0;
               tick_d = 8'h00;
               if (bit_q == 5'h00)
               begin
                  state_d = SSDL_GAP;
               end
               else
               begin
                  bit_d = bit_q - 5'h01;
                  sdat_d = frame_q[bit_q - 5'h01];
               end
            end
         end
         SSDL_GAP:
         begin
            tick_d = tick_q + 8'h01;
            if (tick_q + 8'h01 >= 8'(FALL_TO_LOAD_CYC))
            begin
               tick_d = 8'h00;
               load_d = 1'b1;
               state_d = SSDL_LOAD;
            end
         end
         SSDL_LOAD:
         begin
            tick_d = tick_q + 8'h01;
            if (tick_q + 8'h01 >= 8'(ENABLE_HIGH_CYC))
            begin
               load_d = 1'b0;
               state_d = SSDL_IDLE;
            end
         end
         default:
         begin
            tick_d = 8'h00;
         end
      endcase
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_q <= SSDL_IDLE;
         frame_q <= 25'h0000000;
         bit_q <= 5'h00;
         div_q <= CLKDIV_RESET;
         tick_q <= 8'h00;
         sclk_q <= 1'b0;
         sdat_q <= 1'b0;
         load_q <= 1'b0;
         prdata_out <= 32'h00000000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         frame_q <= frame_d;
         bit_q <= bit_d;
         div_q <= div_d;
         tick_q <= tick_d;
         sclk_q <= sclk_d;
         sdat_q <= sdat_d;
         load_q <= load_d;
         prdata_out <= rdata_d;
         pready_out <= ready_d;
         pslverr_out <= err_d;
      end
   end
   assign link.serial_clk = sclk_q;
   assign link.serial_data = sdat_q;
   assign link.load_strobe = load_q;
endmodule // ssdl_host
`default_nettype wire

// File: dv/ssdl_link_asserts.sv
// Checker: framing and timing assertions on the host-to-device serial link
`default_nettype none
module ssdl_link_asserts
   import ssdl_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_q;
   logic clk_d;
   logic rise;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [24:0] sr_q;
   logic [24:0] sr_d;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // ----------------------------------------
   // Helper: bit count and shadow of the frame
   // ----------------------------------------
   always_comb
   begin
      rise = serial_clk && !clk_q;
      clk_d = serial_clk;
      cnt_d = load_strobe ? 5'h00 : cnt_q + 5'(rise);
      sr_d = rise ? {sr_q[23:0], serial_data} : sr_q;
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         clk_q <= 1'b0;
         cnt_q <= 5'h00;
         sr_q <= 25'h0;
      end
      else
      begin
         clk_q <= clk_d;
         cnt_q <= cnt_d;
         sr_q <= sr_d;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   frame_len_a: assert property ($rose(load_strobe) |-> cnt_q == 5'(FRAME_BITS))
      else $error("frame length is not 25 bits");
   dev_code_a: assert property ($rose(load_strobe) |-> sr_q[24:21] == DEV_CODE)
      else $error("first four bits are not the chip code");
   strobe_idle_a: assert property (load_strobe |-> !serial_clk)
      else $error("serial clock high while strobe high");
   strobe_width_a: assert property ($rose(load_strobe) |-> load_strobe [*2])
      else $error("strobe pulse too short");
   fall_gap_a: assert property ($rose(load_strobe) |-> !serial_clk &&
      !$past(serial_clk, 1) && !$past(serial_clk, 2) && !$past(serial_clk, 3))
      else $error("strobe rose too soon after clock fall");
   enable_lead_a: assert property ($rose(serial_clk) |-> !load_strobe &&
      !$past(load_strobe, 1) && !$past(load_strobe, 2))
      else $error("clock rose too soon after strobe");
   clock_high_a: assert property ($rose(serial_clk) |-> serial_clk [*2])
      else $error("serial clock high time too short");
   data_hold_a: assert property ($rose(serial_clk) |->
      $stable(serial_data) ##1 $stable(serial_data))
      else $error("data moved around the clock rise");
   frame_c: cover property ($rose(load_strobe));
   bit_c: cover property ($rose(serial_clk));
   full_c: cover property ($rose(load_strobe) && cnt_q == 5'h19);
endmodule // ssdl_link_asserts
`default_nettype wire

// File: dv/synth_serial_divider_load_tb_top.sv
// Testbench: host and device ends joined by the serial link, driven over APB
`default_nettype none
module synth_serial_divider_load_tb_top
   import ssdl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, lock;
   logic tone = 1'b0;
   logic tone2 = 1'b0;
   logic brk = 1'b0;
   logic [15:0] ref_div;
   logic [17:0] fb_div, fb_div_b;
   logic [12:0] main_cnt;
   logic [4:0] swal_cnt;
   int errors = 0;
   int total_checks = 0;
   int tcnt = 0;
   ssdl_link_if i_ssdl_link_if ();
   ssdl_link_if i_ssdl_link_if_b ();
   ssdl_host i_ssdl_host (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(i_ssdl_link_if));
   ssdl_device i_ssdl_device (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .link(i_ssdl_link_if), .ref_clk_in(tone), .vco_clk_in(brk ? tone2 : tone),
      .prescaler_sel_in(brk), .ref_div_out(ref_div), .fb_div_out(fb_div),
      .main_count_out(main_cnt), .swallow_count_out(swal_cnt), .lock_indicator_out(lock));
   // Second device faces the bench driver, which breaks the framing on purpose
   ssdl_device i_ssdl_device_b (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .link(i_ssdl_link_if_b), .ref_clk_in(1'b0), .vco_clk_in(1'b0),
      .prescaler_sel_in(1'b0), .ref_div_out(), .fb_div_out(fb_div_b),
      .main_count_out(), .swallow_count_out(), .lock_indicator_out());
   ssdl_link_asserts i_ssdl_link_asserts (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .serial_clk(i_ssdl_link_if.serial_clk), .serial_data(i_ssdl_link_if.serial_data),
      .load_strobe(i_ssdl_link_if.load_strobe));
   initial
   begin
      forever #4 core_clk_in = ~core_clk_in;
   end
   // Tones well below a quarter of the core rate; tone2 drifts against tone
   always @(posedge core_clk_in)
   begin
      tcnt <= (tcnt == 34) ? 0 : tcnt + 1;
      if (tcnt % 5 == 4) tone <= !tone;
      if (tcnt % 7 == 6) tone2 <= !tone2;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk_in);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      chk(32'(pready), 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk(32'(e), 32'(xe));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk(32'(e), 32'(xe));
   endtask
   task automatic idle;
      logic [31:0] r;
      logic e;
      int n = 0;
      do
      begin
         apb(1'b0, APB_STATUS, 32'h0, r, e);
         n++;
      end
      while (r[0] !== 1'b0 && n < 200);
      chk(32'(r[0]), 32'h0);
      repeat (8) @(posedge core_clk_in);
   endtask
   task automatic frame(input logic [4:0] a, input logic [15:0] d);
      wr(APB_CMD, {11'h0, a, d}, 1'b0);
      idle();
   endtask
   task automatic bang(input logic [25:0] w, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         i_ssdl_link_if_b.serial_data <= w[i];
         repeat (4) @(posedge core_clk_in);
         i_ssdl_link_if_b.serial_clk <= 1'b1;
         repeat (8) @(posedge core_clk_in);
         i_ssdl_link_if_b.serial_clk <= 1'b0;
         repeat (4) @(posedge core_clk_in);
      end
      // Released data line shows the inverse, never the last bit
      i_ssdl_link_if_b.serial_data <= ~w[0];
      repeat (4) @(posedge core_clk_in);
      i_ssdl_link_if_b.load_strobe <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      i_ssdl_link_if_b.load_strobe <= 1'b0;
      repeat (8) @(posedge core_clk_in);
   endtask
   task automatic wait_lock(input logic x);
      int n = 0;
      while (lock !== x && n < 5000)
      begin
         @(posedge core_clk_in);
         n++;
      end
      chk(32'(lock), 32'(x));
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge core_clk_in);
      errors++;
      final_report();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      i_ssdl_link_if_b.serial_clk = 1'b0;
      i_ssdl_link_if_b.serial_data = 1'b0;
      i_ssdl_link_if_b.load_strobe = 1'b0;
      repeat (8) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      @(posedge core_clk_in);
      chk(32'(ref_div), 32'(REF_DIV_RESET));
      chk(32'(fb_div), 32'h0);
      chk(32'(lock), 32'h0);
      rd(APB_CLKDIV, 32'(CLKDIV_RESET), 1'b0);
      rd(8'h0c, 32'h0, 1'b1);
      rd(APB_STATUS, 32'h0, 1'b0);
      $display("reset test done");
      wr(APB_CLKDIV, 32'h8, 1'b0);
      rd(APB_CLKDIV, 32'h8, 1'b0);
      frame(ADDR_REF_DIV, 16'h0060);
      chk(32'(ref_div), 32'h60);
      rd(APB_CMD, {7'h0, DEV_CODE, ADDR_REF_DIV, 16'h0060}, 1'b0);
      $display("reference test done");
      frame(ADDR_FB_LOW, 16'h1194);
      frame(ADDR_FB_HIGH, 16'hfffe);
      chk(32'(fb_div), 32'h21194);
      chk(32'(ref_div), 32'h60);
      frame(ADDR_FB_HIGH, 16'h0000);
      chk(32'(fb_div), 32'h01194);
      chk(32'(main_cnt) * 32'h10 - 32'(swal_cnt), 32'h01194);
      $display("feedback test done");
      frame(5'h1f, 16'hbeef);
      chk(32'(ref_div), 32'h60);
      chk(32'(fb_div), 32'h01194);
      wr(APB_CMD, {11'h0, ADDR_REF_DIV, 16'h0007}, 1'b0);
      wr(APB_CMD, {11'h0, ADDR_REF_DIV, 16'h0009}, 1'b1);
      idle();
      chk(32'(ref_div), 32'h7);
      $display("refusal test done");
      frame(ADDR_REF_DIV, 16'h0001);
      frame(ADDR_FB_LOW, 16'h0001);
      wait_lock(1'b1);
      brk <= 1'b1;
      wait_lock(1'b0);
      chk(32'(main_cnt) * 32'h20 - 32'(swal_cnt), 32'h1);
      $display("lock test done");
      bang({1'b0, DEV_CODE, ADDR_FB_LOW, 16'h1234}, 25);
      chk(32'(fb_div_b), 32'h01234);
      bang({1'b0, 4'ha, ADDR_FB_LOW, 16'h5555}, 25);
      chk(32'(fb_div_b), 32'h01234);
      bang({DEV_CODE, ADDR_FB_LOW, 16'h5555, 1'b1}, 26);
      chk(32'(fb_div_b), 32'h01234);
      bang({2'b0, DEV_CODE[2:0], ADDR_FB_LOW, 16'h5555}, 24);
      chk(32'(fb_div_b), 32'h01234);
      $display("framing test done");
      final_report();
   end
endmodule // synth_serial_divider_load_tb_top
`default_nettype wire
